// ==== hdl/tsc_params.svh ====
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH

// Command codes seen in the leading bits
`define TSC_CMD_CFG        3'b100
`define TSC_CMD_PM         8'hC0
`define TSC_CMD_SLEEP      8'hC4
`define TSC_CMD_TX         8'hC6

// Power-on defaults of the command registers
`define TSC_CFG_RESET      16'h8080
`define TSC_PM_RESET       16'hC000
`define TSC_SLEEP_RESET    16'hC400

// Configuration word fields
`define TSC_CFG_CODE_HI    15
`define TSC_CFG_CODE_LO    13
`define TSC_CFG_BAND_HI    12
`define TSC_CFG_BAND_LO    11
`define TSC_CFG_DIV_HI     10
`define TSC_CFG_DIV_LO     8
`define TSC_CFG_XTAL_HI    7
`define TSC_CFG_XTAL_LO    4
`define TSC_CFG_SIGN       3
`define TSC_CFG_DEV_HI     2
`define TSC_CFG_DEV_LO     0

// Power management word fields
`define TSC_PM_A1          7
`define TSC_PM_A0          6
`define TSC_PM_EX          5
`define TSC_PM_ES          4
`define TSC_PM_EA          3
`define TSC_PM_EB          2
`define TSC_PM_ET          1
`define TSC_PM_DC          0

// Upper byte and sleep tail count fields
`define TSC_CODE_HI        15
`define TSC_CODE_LO        8
`define TSC_TAIL_HI        7
`define TSC_TAIL_LO        0

// Bit counter end points in the shift clock domain
`define TSC_BYTE_LAST      4'h7
`define TSC_WORD_LAST      4'hF

// Timing, in the printed units, and the system clock period
`define TSC_CLK_PERIOD_NS  40
`define TSC_POR_TIMEOUT_MS 50
`define TSC_XTAL_START_MS  5
`define TSC_PLL_START_US   250
`define TSC_NS_PER_MS      1000000
`define TSC_NS_PER_US      1000
`define TSC_TIMER_W        24

// System clock cycles per output clock period, codes 0 to 7
`define TSC_CLKOUT_CYC_0   5'h19
`define TSC_CLKOUT_CYC_1   5'h14
`define TSC_CLKOUT_CYC_2   5'h0F
`define TSC_CLKOUT_CYC_3   5'h0C
`define TSC_CLKOUT_CYC_4   5'h0A
`define TSC_CLKOUT_CYC_5   5'h07
`define TSC_CLKOUT_CYC_6   5'h05
`define TSC_CLKOUT_CYC_7   5'h02

`endif

// ==== hdl/tsc_pkg.sv ====
package tsc_pkg;

    // Automatic power sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_OSC  = 3'b001,
        SEQ_SYN  = 3'b010,
        SEQ_RUN  = 3'b011,
        SEQ_TAIL = 3'b100
    } tsc_seq_t;

    // Shift clock domain, cleared while the select is high
    typedef struct packed {
        logic [3:0]  cnt;
        logic [15:0] sh;
        logic        dmode;
    } tsc_shift_t;

    // Shift clock domain, hand-off words and toggles
    typedef struct packed {
        logic [15:0] word;
        logic        wtgl;
        logic        ttgl;
        logic        tbit;
    } tsc_hand_t;

    // System clock domain state
    typedef struct packed {
        logic [1:0]  wt_sync;
        logic [1:0]  tc_sync;
        logic [1:0]  bit_sync;
        logic [1:0]  fsk_sync;
        logic [1:0]  lbd_sync;
        logic [1:0]  wk_sync;
        logic        wt_prev;
        logic        tc_prev;
        logic [15:0] cfg;
        logic [15:0] pm;
        logic [15:0] slp;
        logic [23:0] por_cnt;
        logic        por_busy;
        tsc_seq_t    seq;
        logic [23:0] tmr;
        logic        evt_pend;
        logic        osc;
        logic        syn;
        logic        amp;
        logic        clk_en;
        logic        sign;
        logic        txa;
    } tsc_core_t;

endpackage

// ==== hdl/tsc_link_if.sv ====
`timescale 1ns/100ps
// Words and events handed from the shift clock domain to the core
interface tsc_link_if;
    logic [15:0] word;      // Last complete sixteen-bit command
    logic        word_tgl;  // Flips once per complete sixteen-bit command
    logic        tx_tgl;    // Flips once per data transmit command
    logic        tx_bit;    // Latest transmit data bit

    modport shifter (output word, output word_tgl, output tx_tgl,
                     output tx_bit);
    modport core    (input word, input word_tgl, input tx_tgl,
                     input tx_bit);
endinterface

// ==== hdl/tsc_shifter.sv ====
`timescale 1ns/100ps
`include "tsc_params.svh"
module tsc_shifter
    import tsc_pkg::*;
(
    input  wire logic sck_in,            // Host shift clock
    input  wire logic chip_select_n_in,  // Low during a command frame
    input  wire logic serial_in_pin_in,  // Serial data, MSB first
    input  wire logic rst_n_in,          // Power-on reset, low active
    tsc_link_if.shifter lk               // Hand-off to the core
);

    tsc_shift_t s_q;    // Frame state
    tsc_shift_t s_d;    // Frame next state
    tsc_hand_t  h_q;    // Hand-off registers
    tsc_hand_t  h_d;    // Hand-off next values
    logic [15:0] nsh;   // Shift value after this edge

    // Shift one bit per rising edge and spot command boundaries
    always_comb begin
        s_d = s_q;
        h_d = h_q;
        nsh = {s_q.sh[14:0], serial_in_pin_in};
        if (s_q.dmode) begin
            // After the transmit command bits are data, not commands
            h_d.tbit = serial_in_pin_in;
        end else begin
            s_d.sh  = nsh;
            s_d.cnt = 4'(s_q.cnt + 4'h1);
            if (s_q.cnt == `TSC_BYTE_LAST &&
                nsh[`TSC_BYTE_LAST:0] == `TSC_CMD_TX) begin
                // Eight-bit transmit command ends on a byte boundary
                s_d.dmode = 1'b1;
                s_d.cnt   = 4'h0;
                h_d.ttgl  = ~h_q.ttgl;
            end else if (s_q.cnt == `TSC_WORD_LAST) begin
                // Only a whole word leaves this domain
                h_d.word  = nsh;
                h_d.wtgl  = ~h_q.wtgl;
                s_d.cnt   = 4'h0;
            end
        end
    end

    // Select high clears the partial command; the clock stops anyway
    always_ff @(posedge sck_in or posedge chip_select_n_in
                or negedge rst_n_in) begin
        if (chip_select_n_in || !rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Hand-off survives the select; it must hold until the core reads
    always_ff @(posedge sck_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            h_q <= '0;
        end else begin
            h_q <= h_d;
        end
    end

    assign lk.word     = h_q.word;
    assign lk.word_tgl = h_q.wtgl;
    assign lk.tx_tgl   = h_q.ttgl;
    assign lk.tx_bit   = h_q.tbit;

endmodule

// ==== hdl/tsc_ctrl.sv ====
// Operation
// - Data sampled on shift clock rising edges
// - Select high clears any partial command
// - Commands arrive MSB first, code leads
// - Reset loads register defaults
// - Configuration word code 100 sets fields
// - Band codes select 433, 868, 915
// - Crystal load in half picofarad steps
// - Divider code selects output clock rate
// - Deviation sign is bit XOR modulation pin
// - Power management word layout and default
// - Enable bits switch blocks directly
// - Transmit command drives automatic power control
// - Oscillator, then synthesizer, then amplifier
// - Oscillator forced on while handling events
// - Sleep resets the event controller
// - Commands ignored during power-on timeout
// - Sleep cuts amp, synth; oscillator after tail
// - Bits after transmit command are data
`timescale 1ns/100ps
`include "tsc_params.svh"
module tsc_ctrl
    import tsc_pkg::*;
#(
    // Power-on command lockout, rounded down from the longest time
    parameter int unsigned POR_TIMEOUT_CYC =
        (`TSC_POR_TIMEOUT_MS * `TSC_NS_PER_MS) / `TSC_CLK_PERIOD_NS,
    // Oscillator start wait, rounded up from the least time
    parameter int unsigned XTAL_START_CYC =
        (`TSC_XTAL_START_MS * `TSC_NS_PER_MS + `TSC_CLK_PERIOD_NS - 1)
        / `TSC_CLK_PERIOD_NS,
    // Synthesizer lock wait, rounded up from the least time
    parameter int unsigned PLL_LOCK_CYC =
        (`TSC_PLL_START_US * `TSC_NS_PER_US + `TSC_CLK_PERIOD_NS - 1)
        / `TSC_CLK_PERIOD_NS
) (
    input  wire logic       clk_in,                  // 25 MHz clock
    input  wire logic       rst_n_in,                // Reset, sync in the core, async in the shifter
    input  wire logic       sck_in,                  // Host shift clock
    input  wire logic       chip_select_n_in,        // Frame select
    input  wire logic       serial_in_pin_in,        // Serial data
    input  wire logic       modulation_input_pin_in, // MODULATION_INPUT_PIN level
    input  wire logic       low_battery_event_in,    // Detector trip
    input  wire logic       wake_timer_event_in,     // Timer expiry
    output logic            osc_enable_out,          // Crystal oscillator
    output logic            synth_enable_out,        // Synthesizer
    output logic            amp_enable_out,          // Power amplifier
    output logic            batt_detect_enable_out,  // Battery detector
    output logic            wake_timer_enable_out,   // Wake-up timer
    output logic            clkout_enable_out,       // Clock out buffer
    output logic [1:0]      band_select_out,         // Band code
    output logic [2:0]      clkout_divider_sel_out,  // Clock out rate
    output logic [3:0]      xtal_load_sel_out,       // Load capacitance
    output logic            deviation_sign_out,      // Deviation sign
    output logic [2:0]      deviation_step_out,      // Deviation step
    output logic            tx_data_out,             // Transmit data bit
    output logic            tx_active_out,           // Sequencer running
    output logic            por_busy_out,            // Lockout active
    output logic            event_pending_out        // Event handling
);

    // Counts must fit the shared timer and be at least one cycle
    if (POR_TIMEOUT_CYC < 1 || POR_TIMEOUT_CYC >= (1 << `TSC_TIMER_W) ||
        XTAL_START_CYC < 1 || XTAL_START_CYC >= (1 << `TSC_TIMER_W) ||
        PLL_LOCK_CYC < 1 || PLL_LOCK_CYC >= (1 << `TSC_TIMER_W))
    begin : g_bad_count
        $error("tsc_ctrl: timing count out of range");
    end

    tsc_link_if lk ();  // Crossing bundle from the shift domain

    // Shift clock domain front end
    tsc_shifter u_shifter (
        .sck_in           (sck_in),
        .chip_select_n_in (chip_select_n_in),
        .serial_in_pin_in (serial_in_pin_in),
        .rst_n_in         (rst_n_in),
        .lk               (lk.shifter)
    );

    tsc_core_t   q;          // Registered state
    tsc_core_t   d;          // Next state
    logic        word_evt;   // A whole command word arrived
    logic        tx_evt;     // A transmit command arrived
    logic        sleep_evt;  // A sleep command was taken
    logic        por_done;   // Lockout ends this cycle
    logic        evt_set;    // A power-on, battery or wake-up event occurred
    logic [15:0] cmd;        // Word under decode
    logic [4:0]  per_cyc;    // Output clock period in cycles
    logic [23:0] tail_cyc;   // Sleep tail length in cycles

    // Output clock period for the sleep tail, per divider code
    function automatic logic [4:0] clkout_cycles(input logic [2:0] sel);
        logic [4:0] r;
        r = `TSC_CLKOUT_CYC_0;
        case (sel)
            3'h0: r = `TSC_CLKOUT_CYC_0;
            3'h1: r = `TSC_CLKOUT_CYC_1;
            3'h2: r = `TSC_CLKOUT_CYC_2;
            3'h3: r = `TSC_CLKOUT_CYC_3;
            3'h4: r = `TSC_CLKOUT_CYC_4;
            3'h5: r = `TSC_CLKOUT_CYC_5;
            3'h6: r = `TSC_CLKOUT_CYC_6;
            3'h7: r = `TSC_CLKOUT_CYC_7;
            default: r = `TSC_CLKOUT_CYC_0;
        endcase
        return r;
    endfunction

    // Next-state logic: crossings, decode, sequencer, outputs
    always_comb begin
        d = q;
        // Two-stage synchronisers; stage one feeds stage two only
        d.wt_sync  = {q.wt_sync[0], lk.word_tgl};
        d.tc_sync  = {q.tc_sync[0], lk.tx_tgl};
        d.bit_sync = {q.bit_sync[0], lk.tx_bit};
        d.fsk_sync = {q.fsk_sync[0], modulation_input_pin_in};
        d.lbd_sync = {q.lbd_sync[0], low_battery_event_in};
        d.wk_sync  = {q.wk_sync[0], wake_timer_event_in};
        d.wt_prev  = q.wt_sync[1];
        d.tc_prev  = q.tc_sync[1];

        // Edges are consumed during lockout so nothing replays later
        word_evt = (q.wt_sync[1] != q.wt_prev) && !q.por_busy;
        tx_evt   = (q.tc_sync[1] != q.tc_prev) && !q.por_busy;
        cmd      = lk.word;  // Held stable since its toggle flipped
        sleep_evt = 1'b0;
        per_cyc  = clkout_cycles(q.cfg[`TSC_CFG_DIV_HI:`TSC_CFG_DIV_LO]);

        // Power-on lockout counter
        por_done = 1'b0;
        if (q.por_busy) begin
            d.por_cnt = 24'(q.por_cnt + 24'h000001);
            if (q.por_cnt == 24'(POR_TIMEOUT_CYC - 1)) begin
                d.por_busy = 1'b0;
                por_done   = 1'b1;
            end
        end

        // Command decode on the leading code bits
        if (word_evt) begin
            if (cmd[`TSC_CFG_CODE_HI:`TSC_CFG_CODE_LO] == `TSC_CMD_CFG)
            begin
                d.cfg = cmd;
            end else if (cmd[`TSC_CODE_HI:`TSC_CODE_LO] == `TSC_CMD_PM)
            begin
                d.pm = cmd;
            end else if (cmd[`TSC_CODE_HI:`TSC_CODE_LO] == `TSC_CMD_SLEEP)
            begin
                d.slp     = cmd;
                sleep_evt = 1'b1;
            end
        end

        // Sequencer timing
        case (q.seq)
            SEQ_IDLE: begin
                d.seq = SEQ_IDLE;
            end
            SEQ_OSC: begin
                // Reference settling before the synthesizer starts
                if (q.tmr == 24'h000000) begin
                    d.seq = SEQ_SYN;
                    d.tmr = 24'(PLL_LOCK_CYC - 1);
                end else begin
                    d.tmr = 24'(q.tmr - 24'h000001);
                end
            end
            SEQ_SYN: begin
                // Lock delay before the amplifier may come on
                if (q.tmr == 24'h000000) begin
                    d.seq = SEQ_RUN;
                end else begin
                    d.tmr = 24'(q.tmr - 24'h000001);
                end
            end
            SEQ_RUN: begin
                d.seq = SEQ_RUN;
            end
            SEQ_TAIL: begin
                // Oscillator lingers so the host can finish its work
                if (q.tmr == 24'h000000) begin
                    d.seq = SEQ_IDLE;
                end else begin
                    d.tmr = 24'(q.tmr - 24'h000001);
                end
            end
            default: begin
                d.seq = SEQ_IDLE;
            end
        endcase

        // Transmit command starts the automatic power-up
        if (tx_evt && q.seq != SEQ_RUN) begin
            if (q.pm[`TSC_PM_A1]) begin
                if (q.osc) begin
                    // Reference already stable, go straight to lock
                    d.seq = SEQ_SYN;
                    d.tmr = 24'(PLL_LOCK_CYC - 1);
                end else begin
                    d.seq = SEQ_OSC;
                    d.tmr = 24'(XTAL_START_CYC - 1);
                end
            end else begin
                // Oscillator and synthesizer left to the direct bits
                d.seq = SEQ_RUN;
            end
        end

        // Sleep: cut amplifier and synthesizer now, oscillator later;
        // the tail ends one edge after zero, so it is loaded one short
        tail_cyc = 24'(d.slp[`TSC_TAIL_HI:`TSC_TAIL_LO]) * 24'(per_cyc);
        if (sleep_evt) begin
            if (q.pm[`TSC_PM_A1] && !q.pm[`TSC_PM_EX] &&
                q.seq != SEQ_IDLE && tail_cyc != 24'h000000) begin
                d.seq = SEQ_TAIL;
                d.tmr = 24'(tail_cyc - 24'h000001);
            end else begin
                d.seq = SEQ_IDLE;
            end
        end

        // Event controller; a new event beats a sleep clear
        evt_set = por_done ||
                  (q.lbd_sync[1] && q.pm[`TSC_PM_EB]) ||
                  (q.wk_sync[1] && q.pm[`TSC_PM_ET]);
        d.evt_pend = evt_set || (q.evt_pend && !sleep_evt);

        // Block enables: direct bits, automatic control, event hold
        d.osc = d.pm[`TSC_PM_EX] ||
                (d.pm[`TSC_PM_A1] && d.seq != SEQ_IDLE) ||
                d.por_busy || d.evt_pend;
        d.syn = d.pm[`TSC_PM_ES] ||
                (d.pm[`TSC_PM_A1] &&
                 (d.seq == SEQ_SYN || d.seq == SEQ_RUN));
        d.amp = d.pm[`TSC_PM_EA] ||
                (d.pm[`TSC_PM_A0] && d.seq == SEQ_RUN);
        d.clk_en = !d.pm[`TSC_PM_DC] && d.osc;
        d.sign   = d.cfg[`TSC_CFG_SIGN] ^ q.fsk_sync[1];
        // Run flag kept in a flop so the output needs no decode
        d.txa    = (d.seq == SEQ_RUN);
    end

    // State register; reset restores every default
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q          <= '0;
            q.cfg      <= `TSC_CFG_RESET;
            q.pm       <= `TSC_PM_RESET;
            q.slp      <= `TSC_SLEEP_RESET;
            q.por_busy <= 1'b1;
            q.osc      <= 1'b1;
            q.seq      <= SEQ_IDLE;
        end else begin
            q <= d;
        end
    end

    // Outputs come straight from the state register
    assign osc_enable_out         = q.osc;
    assign synth_enable_out       = q.syn;
    assign amp_enable_out         = q.amp;
    assign batt_detect_enable_out = q.pm[`TSC_PM_EB];
    assign wake_timer_enable_out  = q.pm[`TSC_PM_ET];
    assign clkout_enable_out      = q.clk_en;
    assign band_select_out =
        q.cfg[`TSC_CFG_BAND_HI:`TSC_CFG_BAND_LO];
    assign clkout_divider_sel_out =
        q.cfg[`TSC_CFG_DIV_HI:`TSC_CFG_DIV_LO];
    assign xtal_load_sel_out =
        q.cfg[`TSC_CFG_XTAL_HI:`TSC_CFG_XTAL_LO];
    assign deviation_sign_out     = q.sign;
    // Code 7 passes through; the host is expected to avoid it
    assign deviation_step_out =
        q.cfg[`TSC_CFG_DEV_HI:`TSC_CFG_DEV_LO];
    assign tx_data_out            = q.bit_sync[1];
    assign tx_active_out          = q.txa;
    assign por_busy_out           = q.por_busy;
    assign event_pending_out      = q.evt_pend;

    // Checks on the core domain
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_reset_defaults: assert property (
        $rose(rst_n_in) |-> (q.cfg == `TSC_CFG_RESET &&
            q.pm == `TSC_PM_RESET && q.slp == `TSC_SLEEP_RESET &&
            por_busy_out && osc_enable_out))
        else $error("defaults not loaded by reset");

    a_por_lockout: assert property (
        q.por_busy |=> ($stable(q.cfg) && $stable(q.pm)))
        else $error("register changed during power-on lockout");

    a_por_osc_on: assert property (
        (por_busy_out || event_pending_out) |-> osc_enable_out)
        else $error("oscillator off while handling an event");

    a_cfg_write: assert property (
        (word_evt && cmd[`TSC_CFG_CODE_HI:`TSC_CFG_CODE_LO] == `TSC_CMD_CFG)
        |=> (q.cfg == $past(cmd)))
        else $error("configuration word not stored");

    a_seq_start: assert property (
        (tx_evt && q.pm[`TSC_PM_A1] && !q.osc && q.seq == SEQ_IDLE)
        |=> (q.seq == SEQ_OSC && q.tmr == 24'(XTAL_START_CYC - 1)
             && osc_enable_out && !tx_active_out))
        else $error("transmit command did not start the oscillator");

    a_osc_to_syn: assert property (
        (q.seq == SEQ_OSC && q.tmr == 24'h000000 && !sleep_evt)
        |=> (q.seq == SEQ_SYN && synth_enable_out == q.pm[`TSC_PM_A1]))
        else $error("synthesizer did not follow the oscillator");

    a_amp_cause: assert property (
        (amp_enable_out && !q.pm[`TSC_PM_EA])
        |-> (q.pm[`TSC_PM_A0] && q.seq == SEQ_RUN))
        else $error("amplifier on without cause");

    a_sleep_cuts: assert property (
        (sleep_evt && !d.pm[`TSC_PM_EA] && !d.pm[`TSC_PM_ES])
        |=> (!amp_enable_out && !synth_enable_out))
        else $error("sleep left amplifier or synthesizer on");

    a_tail_osc: assert property (
        (q.seq == SEQ_TAIL && q.pm[`TSC_PM_A1]) |-> osc_enable_out)
        else $error("oscillator stopped before the tail ended");

    a_sleep_clears: assert property (
        (sleep_evt && !evt_set) |=> !event_pending_out)
        else $error("sleep did not clear pending event");

    a_sign_follow: assert property (
        1'b1 |=> (deviation_sign_out ==
                  ($past(d.cfg[`TSC_CFG_SIGN]) ^ $past(q.fsk_sync[1]))))
        else $error("deviation sign mismatch");

    c_tx_run:   cover property (q.seq == SEQ_SYN ##1 q.seq == SEQ_RUN);
    c_tail_end: cover property (q.seq == SEQ_TAIL ##1 q.seq == SEQ_IDLE);
    c_cfg_wr:   cover property (word_evt ##1 $changed(q.cfg));
    c_evt_hold: cover property ($fell(por_busy_out) ##1 event_pending_out);

endmodule

// ==== dv/tsc_host.sv ====
`timescale 1ns/100ps
// Host side of the serial port; shift clock runs only inside frames
module tsc_host (
    output logic sck_out,   // Shift clock, idle low
    output logic cs_n_out,  // Frame select, low active
    output logic sdi_out    // Serial data
);
    // Idle: deselected, clock still
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b0;
    end
    // Send n leading bits of w, 48 ns per bit, whole bytes only
    task automatic send(input logic [15:0] w, input int n);
        cs_n_out = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            #12 sdi_out = w[i];
            #12 sck_out = 1'b1;
            #24 sck_out = 1'b0;
        end
        #12 cs_n_out = 1'b1;
        // Released line must not keep its last value
        sdi_out = ~sdi_out;
        #36;
    endtask
endmodule

// ==== dv/tsc_ctrl_test.sv ====
`timescale 1ns/100ps
module tsc_ctrl_test;
    logic        clk_in, rst_n_in, modulation_input_pin, low_battery_event, wke;  // Bench inputs
    logic        sck, cs_n, serial_in_pin;                    // Host wires
    logic        osc, syn, amp, bat, wkt, cko;      // Power outputs
    logic        sgn, txd, txa, por, evp;           // Status outputs
    logic [1:0]  band;
    logic [2:0]  div, step;
    logic [3:0]  xtal;
    logic [15:0] w;
    logic [12:0] cf;                                // Settings view
    assign cf = {band, div, xtal, sgn, step};
    int          fail_count, n_compared, cyc;

    // Short waits keep the run brief; expectations use these values
    tsc_ctrl #(.POR_TIMEOUT_CYC(50), .XTAL_START_CYC(20),
        .PLL_LOCK_CYC(10)) u_tsc_ctrl (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .sck_in(sck), .chip_select_n_in(cs_n),
        .serial_in_pin_in(serial_in_pin), .modulation_input_pin_in(modulation_input_pin),
        .low_battery_event_in(low_battery_event), .wake_timer_event_in(wke),
        .osc_enable_out(osc), .synth_enable_out(syn),
        .amp_enable_out(amp), .batt_detect_enable_out(bat),
        .wake_timer_enable_out(wkt), .clkout_enable_out(cko),
        .band_select_out(band), .clkout_divider_sel_out(div),
        .xtal_load_sel_out(xtal), .deviation_sign_out(sgn),
        .deviation_step_out(step), .tx_data_out(txd),
        .tx_active_out(txa), .por_busy_out(por),
        .event_pending_out(evp));
    tsc_host u_tsc_host (.sck_out(sck), .cs_n_out(cs_n), .sdi_out(serial_in_pin));

    // 25 MHz system clock
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // Hang guard, well above the expected few hundred cycles
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // Verdict and end of run
    task automatic tally_and_finish();
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Compare one result
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // Whole command, then room for the crossing latency
    task automatic cmd(input logic [15:0] c);
        u_tsc_host.send(c, 16);
        wt(8);
    endtask

    initial begin
        rst_n_in = 1'b0;
        modulation_input_pin = 1'b0;
        low_battery_event = 1'b0;
        wke = 1'b0;
        wt(16);
        rst_n_in = 1'b1;
        chk("config", 16'h0080, cf);
        chk("por_busy", 16'h1, por);
        // Word landing inside the lockout is dropped
        cmd(16'h9FFF);
        chk("config", 16'h0080, cf);
        wt(40);
        chk("por_evt", 16'h3, {por, evp, osc});
        // Band codes 1 to 3 with fixed other fields
        for (int b = 1; b < 4; b++) begin
            w = {3'b100, 2'(b), 11'h2B5};
            cmd(w);
            chk("config", {3'h0, w[12:0]}, cf);
        end
        modulation_input_pin = 1'b1;
        wt(5);
        chk("sign", 16'h1, sgn);
        // Cut-short byte leaves settings and alignment intact
        u_tsc_host.send(16'h8000, 8);
        wt(8);
        chk("config", {3'h0, w[12:0]} ^ 16'h8, cf);
        cmd(16'h8808);
        chk("config", 16'h0800, cf);
        cmd(16'hC03E);
        chk("enables", 16'h3F, {osc, syn, amp, bat, wkt, cko});
        cmd(16'hC0C1);
        chk("enables", 16'h20, {osc, syn, amp, bat, wkt, cko});
        cmd(16'hC400);
        chk("evt_osc", 16'h0, {evp, osc});
        cmd(16'hC0C0);
        // Transmit command followed by data bits in one frame
        u_tsc_host.send(16'hC6FF, 16);
        wt(1);
        chk("osc_syn", 16'h2, {osc, syn});
        wt(18);
        chk("syn_amp", 16'h2, {syn, amp});
        wt(10);
        chk("run", 16'h7, {amp, txa, txd});
        // Sleep with a two period tail at 25 clocks each
        cmd(16'hC402);
        chk("sleep", 16'h4, {osc, syn, amp});
        wt(30);
        chk("tail", 16'h1, osc);
        wt(20);
        chk("tail", 16'h0, osc);
        cmd(16'hC0C4);
        low_battery_event = 1'b1;
        wt(4);
        low_battery_event = 1'b0;
        wt(2);
        chk("lbd_evt", 16'h3, {evp, osc});
        // Wake-up timer event takes the same path once cleared
        cmd(16'hC400);
        chk("evt_clr", 16'h0, {evp, osc});
        cmd(16'hC0C2);
        wke = 1'b1;
        wt(4);
        wke = 1'b0;
        wt(2);
        chk("wake_evt", 16'h7, {evp, osc, wkt});
        tally_and_finish();
    end
endmodule
